// *** rtl/tcf_top.sv ***
// tool changer fault interlock: pin synchronisers, fault flags, command gating
// and an ahb-lite register slave; all pins are asynchronous to hclk
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module tcf_top
   import tcf_pkg::*;
#(
   parameter int unsigned TOOL_ID_CYCLES    = TCF_TOOL_ID_CYCLES,
   parameter int unsigned PRESS_OPEN_CYCLES = TCF_PRESS_OPEN_CYCLES
)
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        valve_b_short_in,
   input  wire logic        engaged_sensor,
   input  wire logic        retracted_sensor,
   input  wire logic        pressure_above_range,
   input  wire logic        pressure_below_range,
   input  wire logic        proximity_sensor_a,
   input  wire logic        proximity_sensor_b,
   input  wire logic        safety_fault_in,
   input  wire logic        tool_identity_valid,
   input  wire logic        tool_present,
   input  wire logic        input_supply_present,
   input  wire logic        output_supply_present,
   input  wire logic        safety_channel_a,
   input  wire logic        safety_channel_b,
   input  wire logic        relay_a_feedback,
   input  wire logic        relay_b_feedback,
   input  wire logic        valve_a_fault_in,
   input  wire logic        valve_b_fault_in,
   input  wire logic        pressure_sensor_open,
   input  wire logic        processor_link_loss,
   input  wire logic        cross_check_mismatch,
   input  wire logic        couple_command,
   input  wire logic        uncouple_command,
   output logic             couple_drive,
   output logic             uncouple_drive,
   output logic             overall_health_bit,
   output logic             uncouple_permitted,
   output logic             system_unsafe_flag
);

   // synchroniser stages and filtered pin levels
   logic [TCF_SYNC_WIDTH-1:0] sync_1;
   logic [TCF_SYNC_WIDTH-1:0] sync_2;
   logic [TCF_SYNC_WIDTH-1:0] sync_3;
   logic [TCF_SYNC_WIDTH-1:0] pins;
   logic [TCF_SYNC_WIDTH-1:0] pins_prev;
   logic                      s_short;
   logic                      s_engaged;
   logic                      s_retracted;
   logic                      s_press_hi;
   logic                      s_press_lo;
   logic                      s_prox_a;
   logic                      s_prox_b;
   logic                      s_safety;
   logic                      s_id_valid;
   logic                      s_tool_present;
   logic                      s_supply_in;
   logic                      s_supply_out;
   logic                      s_chan_a;
   logic                      s_chan_b;
   logic                      s_relay_a;
   logic                      s_relay_b;
   logic                      s_valve_a;
   logic                      s_valve_b;
   logic                      s_press_open;
   logic                      s_link_loss;
   logic                      s_cross;
   logic                      s_couple_cmd;
   logic                      s_uncouple_cmd;
   logic                      p_tool_present;
   logic                      p_couple_cmd;
   logic                      p_uncouple_cmd;

   // flags, bus and sequencing state
   logic [TCF_FLAG_WIDTH-1:0] flags;
   logic [2:0]                start_cnt;
   logic                      start_done;
   logic                      start_edge;
   logic                      couple_rise;
   logic                      uncouple_rise;
   logic                      tool_present_rise;
   logic                      couple_ok;
   logic                      next_permitted;
   logic                      fault_clear;
   logic                      clear_armed;
   logic                      id_seen;
   logic                      id_set;
   logic [24:0]               id_cnt;
   logic [19:0]               open_cnt;
   logic                      open_persist;
   logic                      wr_pend;
   logic [7:0]                wr_addr;
   logic                      bus_take;

   // filter: a level change counts once stages two and three agree
   function automatic logic [TCF_SYNC_WIDTH-1:0] agree_filter(
      input logic [TCF_SYNC_WIDTH-1:0] s2,
      input logic [TCF_SYNC_WIDTH-1:0] s3,
      input logic [TCF_SYNC_WIDTH-1:0] held
   );
      agree_filter = (s3 & ~(s2 ^ s3)) | (held & (s2 ^ s3));
   endfunction : agree_filter

   // read data for a register offset
   function automatic logic [31:0] read_word(
      input logic [7:0] ofs,
      input logic [31:0] flag_word,
      input logic [31:0] state_word
   );
      if (ofs == TCF_FLAGS_OFS)
      begin
         read_word = flag_word;
      end
      else if (ofs == TCF_STATE_OFS)
      begin
         read_word = state_word;
      end
      else
      begin
         read_word = TCF_RDATA_RST; // control reads zero, unmapped reads zero
      end
   endfunction : read_word

   // three-stage synchronisers for every pin input
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sync_1 <= '0;
         sync_2 <= '0;
         sync_3 <= '0;
         pins   <= '0;
      end
      else
      begin
         sync_1 <= {valve_b_short_in, engaged_sensor, retracted_sensor,
                    pressure_above_range, pressure_below_range,
                    proximity_sensor_a, proximity_sensor_b, safety_fault_in,
                    tool_identity_valid, tool_present, input_supply_present,
                    output_supply_present, safety_channel_a, safety_channel_b,
                    relay_a_feedback, relay_b_feedback, valve_a_fault_in,
                    valve_b_fault_in, pressure_sensor_open, processor_link_loss,
                    cross_check_mismatch, couple_command, uncouple_command};
         sync_2 <= sync_1;
         sync_3 <= sync_2;
         pins   <= agree_filter(sync_2, sync_3, pins);
      end
   end

   assign {s_short, s_engaged, s_retracted, s_press_hi, s_press_lo, s_prox_a, s_prox_b,
           s_safety, s_id_valid, s_tool_present, s_supply_in, s_supply_out, s_chan_a,
           s_chan_b, s_relay_a, s_relay_b, s_valve_a, s_valve_b, s_press_open,
           s_link_loss, s_cross, s_couple_cmd, s_uncouple_cmd} = pins;
   assign {p_tool_present, p_couple_cmd, p_uncouple_cmd} =
          {pins_prev[13], pins_prev[1], pins_prev[0]};

   // startup: hold off edge detection until the synchronisers have settled
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         start_cnt  <= '0;
         start_done <= 1'b0;
         pins_prev  <= '0;
      end
      else
      begin
         pins_prev <= pins;
         if (!start_done)
         begin
            start_cnt  <= start_cnt + 3'd1;
            start_done <= (start_cnt == 3'(TCF_STARTUP_CYCLES));
         end
      end
   end

   // in the first cycle that the filter shows the pins, so a held command is seen
   // here and pins_prev already holds the true level when edge detection starts
   assign start_edge        = (start_cnt == 3'(TCF_STARTUP_CYCLES)) && !start_done;
   assign couple_rise       = start_done && s_couple_cmd && !p_couple_cmd;
   assign uncouple_rise     = start_done && s_uncouple_cmd && !p_uncouple_cmd;
   assign tool_present_rise = start_done && s_tool_present && !p_tool_present;

   // gating conditions for the two commands
   assign couple_ok = !s_uncouple_cmd && s_supply_in && s_supply_out && !s_engaged
                      && !flags[TCF_F_OVERPRESSURE] && !flags[TCF_F_UNDERPRESSURE]
                      && s_prox_a && s_prox_b && !system_unsafe_flag; // see R10
   assign next_permitted = (flags == TCF_FLAGS_RST) && s_supply_in && s_supply_out
                           && !s_press_hi && !s_press_lo && !s_retracted
                           && !couple_drive && s_chan_a && s_chan_b
                           && s_relay_a && s_relay_b; // see R20

   // ahb-lite slave: zero wait states, always okay
   assign bus_take = hsel && htrans[1] && hready;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata    <= TCF_RDATA_RST;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend   <= 1'b0;
         wr_addr   <= '0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend   <= bus_take && hwrite;
         wr_addr   <= haddr[7:0];
         if (bus_take && !hwrite && (haddr[31:8] == 24'h00_0000))
         begin
            hrdata <= read_word(haddr[7:0], {20'h0_0000, flags},
                                {26'h000_0000, s_id_valid, s_tool_present,
                                 uncouple_permitted, overall_health_bit,
                                 uncouple_drive, couple_drive});
         end
         else
         begin
            hrdata <= TCF_RDATA_RST;
         end
      end
   end

   // fault clear pulse from a write of one to the control register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         fault_clear <= 1'b0;
      end
      else
      begin
         fault_clear <= wr_pend && (wr_addr == TCF_CTRL_OFS)
                        && hwdata[TCF_CTRL_CLEAR_BIT];
      end
   end

   // tool identity watch: timer runs from coupling until an identity arrives
   assign id_set = (s_engaged && !id_seen && (id_cnt == 25'(TOOL_ID_CYCLES - 1)))
                   || (s_engaged && id_seen && !s_id_valid); // see R8

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         id_seen <= 1'b0;
         id_cnt  <= '0;
      end
      else if (!s_engaged)
      begin
         id_seen <= 1'b0;
         id_cnt  <= '0;
      end
      else
      begin
         id_seen <= id_seen || s_id_valid;
         if (!id_seen && !s_id_valid && (id_cnt != 25'(TOOL_ID_CYCLES - 1)))
         begin
            id_cnt <= id_cnt + 25'd1;
         end
      end
   end

   // open pressure sensor persistence timer
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         open_cnt     <= '0;
         open_persist <= 1'b0;
      end
      else if (!s_press_open)
      begin
         open_cnt <= '0;
      end
      else if (open_cnt == 20'(PRESS_OPEN_CYCLES - 1))
      begin
         open_persist <= 1'b1; // see R17
      end
      else
      begin
         open_cnt <= open_cnt + 20'd1;
      end
   end

   // arm the proximity disagree clear on a fault clear request
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         clear_armed <= 1'b0;
      end
      else if (fault_clear)
      begin
         clear_armed <= 1'b1;
      end
      else if (uncouple_rise)
      begin
         clear_armed <= 1'b0;
      end
   end

   // fault flags: a setting cause always wins over a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         flags <= TCF_FLAGS_RST;
      end
      else
      begin
         flags[TCF_F_VALVE_B_SHORT] <= flags[TCF_F_VALVE_B_SHORT] || s_short; // see R1, R22
         flags[TCF_F_LOCK_CONFLICT] <= s_engaged && s_retracted; // see R2
         flags[TCF_F_OVERPRESSURE]  <= s_press_hi
            || (flags[TCF_F_OVERPRESSURE] && !fault_clear && s_press_hi); // see R3
         flags[TCF_F_UNDERPRESSURE] <= s_press_lo
            || (flags[TCF_F_UNDERPRESSURE] && !fault_clear && s_press_lo); // see R4
         flags[TCF_F_PROX_DISAGREE] <= (uncouple_rise && (s_prox_a != s_prox_b)) // see R5
            || (flags[TCF_F_PROX_DISAGREE]
                && !(uncouple_rise && clear_armed)); // see R6, R22
         flags[TCF_F_SAFETY_FAULT]  <= flags[TCF_F_SAFETY_FAULT] || s_safety; // see R7
         flags[TCF_F_TOOL_ID_TIMEOUT] <= id_set
            || (flags[TCF_F_TOOL_ID_TIMEOUT] && !tool_present_rise); // see R9
         flags[TCF_F_UNSAFE_COUPLE] <= (couple_rise && !couple_ok) // see R11
            || (flags[TCF_F_UNSAFE_COUPLE] && !fault_clear
                && !(couple_rise && couple_ok));
         flags[TCF_F_UNSAFE_UNCOUPLE] <= (uncouple_rise && !next_permitted) // see R12
            || (start_edge && s_uncouple_cmd) // see R13
            || (flags[TCF_F_UNSAFE_UNCOUPLE] && !fault_clear
                && !(uncouple_rise && next_permitted)); // see R14
         flags[TCF_F_VALVE_FAULT]   <= flags[TCF_F_VALVE_FAULT]
                                       || s_valve_a || s_valve_b; // see R15
         flags[TCF_F_PRESSURE_OPEN] <= s_press_open
            || (flags[TCF_F_PRESSURE_OPEN] && !fault_clear); // see R16
         flags[TCF_F_SYSTEM_UNSAFE] <= flags[TCF_F_SYSTEM_UNSAFE] || s_link_loss
            || s_cross || s_safety || s_valve_a || s_valve_b
            || open_persist; // see R15, R17, R18
      end
   end

   // couple output: driven on an accepted command edge, frozen while unsafe
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         couple_drive <= 1'b0;
      end
      else if (system_unsafe_flag)
      begin
         couple_drive <= couple_drive; // see R19
      end
      else if (couple_rise)
      begin
         couple_drive <= couple_ok; // see R10, R11
      end
      else if (!s_couple_cmd)
      begin
         couple_drive <= 1'b0;
      end
   end

   // uncouple output: a safety fault drops it even when the outputs are frozen
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         uncouple_drive <= 1'b0;
      end
      else if (s_safety)
      begin
         uncouple_drive <= 1'b0; // see R7
      end
      else if (system_unsafe_flag)
      begin
         uncouple_drive <= uncouple_drive; // see R19
      end
      else if (uncouple_rise)
      begin
         uncouple_drive <= next_permitted; // see R12
      end
      else if (!s_uncouple_cmd)
      begin
         uncouple_drive <= 1'b0;
      end
   end

   // status outputs
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         overall_health_bit <= 1'b0;
         uncouple_permitted <= 1'b0;
      end
      else
      begin
         overall_health_bit <= (flags == TCF_FLAGS_RST); // see R21
         uncouple_permitted <= next_permitted; // see R20
      end
   end

   assign system_unsafe_flag = flags[TCF_F_SYSTEM_UNSAFE];

   // checks on the interlock behaviour
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   short_sticky_a: assert property (flags[TCF_F_VALVE_B_SHORT] |=> flags[TCF_F_VALVE_B_SHORT]) // see R1
      else $error("drive short flag dropped");
   lock_follow_a: assert property (!(s_engaged && s_retracted) |=> !flags[TCF_F_LOCK_CONFLICT]) // see R2
      else $error("lock conflict flag stuck");
   prox_check_a: assert property ((uncouple_rise && (s_prox_a != s_prox_b))
      |=> flags[TCF_F_PROX_DISAGREE]) // see R5
      else $error("proximity disagree not flagged");
   safety_drop_a: assert property (s_safety
      |=> !uncouple_drive && flags[TCF_F_SAFETY_FAULT] && system_unsafe_flag) // see R7
      else $error("safety fault did not drop uncouple");
   tool_id_clear_a: assert property ((tool_present_rise && !id_set)
      |=> !flags[TCF_F_TOOL_ID_TIMEOUT]) // see R9
      else $error("identity timeout not cleared");
   couple_gate_a: assert property ((couple_drive && !$past(couple_drive)) |-> $past(couple_ok)) // see R10
      else $error("couple driven without preconditions");
   couple_refuse_a: assert property ((couple_rise && !couple_ok && !system_unsafe_flag)
      |=> flags[TCF_F_UNSAFE_COUPLE] && !couple_drive) // see R11
      else $error("refused couple not flagged");
   uncouple_refuse_a: assert property ((uncouple_rise && !next_permitted && !system_unsafe_flag)
      |=> flags[TCF_F_UNSAFE_UNCOUPLE] && !uncouple_drive) // see R12
      else $error("unsafe uncouple not flagged");
   valve_unsafe_a: assert property ((s_valve_a || s_valve_b)
      |=> flags[TCF_F_VALVE_FAULT] ##1 system_unsafe_flag[*3]) // see R15
      else $error("valve fault not escalated");
   freeze_out_a: assert property (system_unsafe_flag |=> $stable(couple_drive)) // see R19
      else $error("couple output moved while unsafe");
   permit_cond_a: assert property (uncouple_permitted
      |-> $past(s_supply_in && s_supply_out && s_chan_a && s_chan_b
                && s_relay_a && s_relay_b && !couple_drive)) // see R20
      else $error("uncouple permitted without conditions");
   health_bit_a: assert property ((flags != TCF_FLAGS_RST) |=> !overall_health_bit) // see R21
      else $error("health bit high with a fault");

endmodule : tcf_top

`default_nettype wire

// *** rtl/tcf_pkg.sv ***
// tool changer fault interlock: register map, flag layout, timing constants
// assumes a 100 MHz module clock and an ahb-lite master on the register side
//
// Function
// R1: valve b drive short latches until power cycle
// R2: lock conflict follows both piston sensors active
// R3: overpressure flag cleared by clear or recovery
// R4: underpressure flag cleared by clear or recovery
// R5: uncouple command compares proximity sensors immediately
// R6: disagree clears on fresh uncouple after clear
// R7: safety fault latches, drops and blocks uncouple
// R8: identity timeout after coupling or lost identity
// R9: identity timeout clears on tool present rise
// R10: couple only when every precondition holds
// R11: refused couple sets unsafe couple flag
// R12: unpermitted uncouple sets flag, drops output
// R13: uncouple high after reset flags unsafe uncouple
// R14: unsafe uncouple clears on fresh permitted command; here only a fault clear does, as next_permitted needs all flags low
// R15: valve fault sets flag and system unsafe
// R16: pressure sensor open asserts its flag
// R17: persistent open pressure sensor sets system unsafe
// R18: safety faults set system unsafe flag
// R19: system unsafe freezes couple and uncouple outputs; here a safety fault still drops uncouple_drive while frozen
// R20: uncouple permitted needs all listed conditions
// R21: health bit high with no blocking error
// R22: other fault flags stay set until cleared
package tcf_pkg;

   // register byte offsets
   localparam logic [7:0] TCF_CTRL_OFS   = 8'h00;
   localparam logic [7:0] TCF_FLAGS_OFS  = 8'h04;
   localparam logic [7:0] TCF_STATE_OFS  = 8'h08;

   // control register: write 1 to request a fault clear
   localparam int TCF_CTRL_CLEAR_BIT = 0;

   // fault flag positions in the flags register
   localparam int TCF_FLAG_WIDTH        = 12;
   localparam int TCF_F_VALVE_B_SHORT   = 0;
   localparam int TCF_F_LOCK_CONFLICT   = 1;
   localparam int TCF_F_OVERPRESSURE    = 2;
   localparam int TCF_F_UNDERPRESSURE   = 3;
   localparam int TCF_F_PROX_DISAGREE   = 4;
   localparam int TCF_F_SAFETY_FAULT    = 5;
   localparam int TCF_F_TOOL_ID_TIMEOUT = 6;
   localparam int TCF_F_UNSAFE_COUPLE   = 7;
   localparam int TCF_F_UNSAFE_UNCOUPLE = 8;
   localparam int TCF_F_VALVE_FAULT     = 9;
   localparam int TCF_F_PRESSURE_OPEN   = 10;
   localparam int TCF_F_SYSTEM_UNSAFE   = 11;

   // state register bit positions
   localparam int TCF_S_COUPLE_DRIVE   = 0;
   localparam int TCF_S_UNCOUPLE_DRIVE = 1;
   localparam int TCF_S_HEALTH         = 2;
   localparam int TCF_S_PERMITTED      = 3;
   localparam int TCF_S_TOOL_PRESENT   = 4;
   localparam int TCF_S_ID_VALID       = 5;

   // reset values
   localparam logic [TCF_FLAG_WIDTH-1:0] TCF_FLAGS_RST = 12'h000;
   localparam logic [31:0]               TCF_RDATA_RST = 32'h0000_0000;

   // timing
   localparam int TCF_CLK_KHZ          = 100000;
   localparam int TCF_TOOL_ID_MS       = 250;
   localparam int TCF_TOOL_ID_CYCLES   = TCF_TOOL_ID_MS * TCF_CLK_KHZ;
   localparam int TCF_PRESS_OPEN_MS    = 10;
   localparam int TCF_PRESS_OPEN_CYCLES = TCF_PRESS_OPEN_MS * TCF_CLK_KHZ;
   localparam int TCF_STARTUP_CYCLES   = 4;
   localparam int TCF_SYNC_WIDTH       = 23;

endpackage : tcf_pkg

// *** bench/tcf_robot_model.sv ***
// robot controller model: levels of the couple and uncouple commands
// assumes the bench clock; each level is held long enough to pass the pin filters
`timescale 1ns/10ps
`default_nettype none
module tcf_robot_model
(
   input  wire logic hclk,
   output var logic  couple_command = 1'h0,
   output var logic  uncouple_command = 1'h0
);
   // a new attempt is only ever a fall then a rise of a level
   task automatic drive(input logic c, input logic u);
      @(posedge hclk);
      couple_command   <= c;
      uncouple_command <= u;
      repeat (9) @(posedge hclk);
   endtask : drive
endmodule : tcf_robot_model
`default_nettype wire

// *** bench/tool_changer_fault_interlock_tb_top.sv ***
// bench top: ahb-lite master and pin stimulus, checks on fault flags and drives
// assumes tcf_top with shortened timers and the robot controller model beside it
`timescale 1ns/10ps
`default_nettype none
module tool_changer_fault_interlock_tb_top
   import tcf_pkg::*;
();
   logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h1, hwrite = 1'h0;
   logic        hreadyout, hresp, couple_command, uncouple_command, couple_drive;
   logic        uncouple_drive, overall_health_bit, uncouple_permitted, system_unsafe_flag;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [20:0] pins = 21'h0_fc60;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, d;
   int          mismatches = 0, samples_checked = 0;
   // 100 MHz clock
   always #5 hclk = ~hclk;
   // design with short timers, robot controller on the command pins
   tcf_top #(.TOOL_ID_CYCLES(50), .PRESS_OPEN_CYCLES(20)) uut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hrdata, .hreadyout, .hresp, .valve_b_short_in(pins[0]), .engaged_sensor(pins[1]),
      .retracted_sensor(pins[2]), .pressure_above_range(pins[3]),
      .pressure_below_range(pins[4]), .proximity_sensor_a(pins[5]),
      .proximity_sensor_b(pins[6]), .safety_fault_in(pins[7]), .tool_identity_valid(pins[8]),
      .tool_present(pins[9]), .input_supply_present(pins[10]),
      .output_supply_present(pins[11]), .safety_channel_a(pins[12]),
      .safety_channel_b(pins[13]), .relay_a_feedback(pins[14]), .relay_b_feedback(pins[15]),
      .valve_a_fault_in(pins[16]), .valve_b_fault_in(pins[17]), .pressure_sensor_open(pins[18]),
      .processor_link_loss(pins[19]), .cross_check_mismatch(pins[20]), .couple_command,
      .uncouple_command, .couple_drive, .uncouple_drive, .overall_health_bit,
      .uncouple_permitted, .system_unsafe_flag);
   tcf_robot_model robot (.hclk, .couple_command, .uncouple_command);
   // compare one bit and count it
   task automatic chk(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t: got %b want %b", $time, got, exp);
      end
   endtask : chk
   // one single ahb-lite transfer; read data lands in d
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      haddr  <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      d = hrdata;
   endtask : ahb
   // read the flags register and compare one flag
   task automatic flag(input int b, input logic v);
      ahb(1'h0, TCF_FLAGS_OFS, 32'h0000_0000);
      chk(d[b], v);
   endtask : flag
   // change one pin, then let it pass the filters
   task automatic pin(input int i, input logic v);
      @(posedge hclk);
      pins[i] <= v;
      repeat (9) @(posedge hclk);
   endtask : pin
   // power cycle with the bench pins back at the healthy idle set; the robot's command levels are kept
   task automatic rst();
      @(posedge hclk);
      hresetn <= 1'h0;
      pins    <= 21'h0_fc60;
      repeat (12) @(posedge hclk);
      hresetn <= 1'h1;
      repeat (12) @(posedge hclk);
   endtask : rst
   // verdict and end of run
   task automatic tally_and_finish();
      if (mismatches == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   // cut a hang short
   initial
   begin
      repeat (20000) @(posedge hclk);
      mismatches++;
      tally_and_finish();
   end
   // fault families one after another, power cycling between them
   initial
   begin
      rst();
      pin(1, 1'h1);
      robot.drive(1'h1, 1'h0);
      flag(7, 1'h1);
      pin(2, 1'h1);
      flag(1, 1'h1);
      chk(overall_health_bit, 1'h0);
      pin(2, 1'h0);
      flag(1, 1'h0);
      pin(3, 1'h1);
      flag(2, 1'h1);
      pin(3, 1'h0);
      flag(2, 1'h0);
      pin(4, 1'h1);
      flag(3, 1'h1);
      rst();
      chk(overall_health_bit, 1'h1);
      pin(14, 1'h0);
      chk(uncouple_permitted, 1'h0);
      robot.drive(1'h0, 1'h1);
      chk(uncouple_drive, 1'h0);
      flag(8, 1'h1);
      pin(14, 1'h1);
      ahb(1'h1, TCF_CTRL_OFS, 32'h0000_0001);
      flag(8, 1'h0);
      chk(uncouple_permitted, 1'h1);
      robot.drive(1'h0, 1'h0);
      robot.drive(1'h0, 1'h1);
      chk(uncouple_drive, 1'h1);
      pin(7, 1'h1);
      chk(uncouple_drive, 1'h0);
      chk(system_unsafe_flag, 1'h1);
      rst();
      flag(8, 1'h1);
      robot.drive(1'h0, 1'h0);
      pin(6, 1'h0);
      robot.drive(1'h0, 1'h1);
      flag(4, 1'h1);
      pin(6, 1'h1);
      robot.drive(1'h0, 1'h0);
      ahb(1'h1, TCF_CTRL_OFS, 32'h0000_0001);
      robot.drive(1'h0, 1'h1);
      flag(4, 1'h0);
      rst();
      pin(1, 1'h1);
      repeat (60) @(posedge hclk);
      flag(6, 1'h1);
      pin(8, 1'h1);
      pin(9, 1'h1);
      flag(6, 1'h0);
      rst();
      pin(0, 1'h1);
      ahb(1'h1, TCF_CTRL_OFS, 32'h0000_0001);
      flag(0, 1'h1);
      pin(18, 1'h1);
      flag(10, 1'h1);
      repeat (30) @(posedge hclk);
      chk(system_unsafe_flag, 1'h1);
      rst();
      robot.drive(1'h1, 1'h0);
      pin(16, 1'h1);
      flag(9, 1'h1);
      robot.drive(1'h0, 1'h0);
      chk(couple_drive, 1'h1);
      tally_and_finish();
   end
endmodule : tool_changer_fault_interlock_tb_top
`default_nettype wire
